// File: include/msf_pkg.sv
// Package: offsets, field layout and reset values of the speed/fault registers
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package msf_pkg;

  // -------------------------------------------------------------------------
  // Register indices as printed; byte address is four times the index
  // -------------------------------------------------------------------------
  localparam logic [7:0] FAULT_SETUP_ONE_IDX = 8'h90;
  localparam logic [7:0] FAULT_SETUP_TWO_IDX = 8'h92;
  localparam logic [7:0] SPEED_CURVE_SIX_IDX = 8'h9E;
  localparam int ADDR_SHIFT = 2;

  // -------------------------------------------------------------------------
  // Field positions and reset values
  // -------------------------------------------------------------------------
  localparam int STOP_B_LSB = 23;
  localparam int CLAMP_B_LSB = 15;
  localparam int TORQUE_REF_LSB = 27;
  localparam int SPEED_SCALE = 255;
  localparam logic [31:0] FAULT_RESET = 32'h0000_0000;
  // Arbitrary fill for the undefined-reset register, any value is legal
  localparam logic [31:0] SPEED_SIX_FILL = 32'h0000_0000;

  // Torque current reference in milliamps, indexed by the 4-bit code
  localparam logic [15:0] TORQUE_MA [16] = '{
    16'h007D, 16'h00FA, 16'h01F4, 16'h03E8, 16'h05DC, 16'h07D0,
    16'h09C4, 16'h0BB8, 16'h0DAC, 16'h0FA0, 16'h1194, 16'h1388,
    16'h157C, 16'h1770, 16'h1B58, 16'h1F40};

  // Configuration presented to the motor-control core
  typedef struct packed {
    logic [7:0] motor_stop_threshold_b;
    logic [7:0] clamp_threshold_b;
    logic [3:0] torque_current_reference;
    logic [15:0] torque_current_ma;
  } msf_cfg_t;

endpackage : msf_pkg

// File: src/msf_regs.sv
// Module: APB register bank for speed curve six and fault setup registers
module msf_regs
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Decoded configuration to the control core
  output msf_pkg::msf_cfg_t CFG
);

  logic [31:0] fault_one_reg;
  logic [31:0] fault_two_reg;
  logic [31:0] speed_six_reg;
  logic setup;
  logic [7:0] idx;
  logic hit_one;
  logic hit_two;
  logic hit_six;
  logic mapped;

  // Byte-lane merge used by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  // Answer in setup cycle so the access phase completes with no wait
  assign setup = PSEL && !PENABLE;
  assign idx = PADDR[9:2];
  always_comb
  begin
    hit_one = 1'b0;
    hit_two = 1'b0;
    hit_six = 1'b0;
    if (PADDR[1:0] != 2'b00 || PADDR[11:10] != 2'b00)
      hit_one = 1'b0;
    else if (idx == msf_pkg::FAULT_SETUP_ONE_IDX)
      hit_one = 1'b1;
    else if (idx == msf_pkg::FAULT_SETUP_TWO_IDX)
      hit_two = 1'b1;
    else if (idx == msf_pkg::SPEED_CURVE_SIX_IDX)
      hit_six = 1'b1;
  end
  assign mapped = hit_one || hit_two || hit_six;

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  // Fault setup registers clear on reset
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      fault_one_reg <= msf_pkg::FAULT_RESET;
      fault_two_reg <= msf_pkg::FAULT_RESET;
    end
    else if (PSEL && PENABLE && PWRITE && PREADY)
    begin
      if (idx == msf_pkg::FAULT_SETUP_ONE_IDX && PADDR[1:0] == 2'b00
          && PADDR[11:10] == 2'b00)
        fault_one_reg <= merge(fault_one_reg, PWDATA, PSTRB);
      if (idx == msf_pkg::FAULT_SETUP_TWO_IDX && PADDR[1:0] == 2'b00
          && PADDR[11:10] == 2'b00)
        fault_two_reg <= merge(fault_two_reg, PWDATA, PSTRB);
    end
  end

  // Speed curve six has no defined reset; fill is a don't-care value
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      speed_six_reg <= msf_pkg::SPEED_SIX_FILL;
    else if (PSEL && PENABLE && PWRITE && PREADY && idx ==
             msf_pkg::SPEED_CURVE_SIX_IDX && PADDR[1:0] == 2'b00
             && PADDR[11:10] == 2'b00)
      speed_six_reg <= merge(speed_six_reg, PWDATA, PSTRB);
  end

  // --------------------------------------------------------------------------
  // Bus answer
  // --------------------------------------------------------------------------
  // Read data and status latched in setup so outputs come from flops;
  // unmapped offsets read zero and flag an error, nothing is stored
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= setup;
      PSLVERR <= setup && !mapped;
      if (setup && !PWRITE)
      begin
        if (hit_one)
          PRDATA <= fault_one_reg;
        else if (hit_two)
          PRDATA <= fault_two_reg;
        else if (hit_six)
          PRDATA <= speed_six_reg;
        else
          PRDATA <= 32'h0000_0000;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Decoded configuration
  // --------------------------------------------------------------------------
  // Registered so the core sees a glitch-free copy one cycle after writes
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      CFG <= '0;
    else
    begin
      CFG.motor_stop_threshold_b <=
        speed_six_reg[msf_pkg::STOP_B_LSB +: 8];
      CFG.clamp_threshold_b <=
        speed_six_reg[msf_pkg::CLAMP_B_LSB +: 8];
      CFG.torque_current_reference <=
        fault_one_reg[msf_pkg::TORQUE_REF_LSB +: 4];
      CFG.torque_current_ma <= msf_pkg::TORQUE_MA[
        fault_one_reg[msf_pkg::TORQUE_REF_LSB +: 4]];
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  // Helper: speed curve six means nothing until software has written it
  logic six_written_reg;
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      six_written_reg <= 1'b0;
    else if (PSEL && PENABLE && PWRITE && PREADY && hit_six)
      six_written_reg <= 1'b1;
  end

  // Reset behaviour
  a_fault_reset_zero: assert property (@(posedge MCLK)
    $rose(RESETN) |-> fault_one_reg == 32'h0 && fault_two_reg == 32'h0)
    else $error("fault setup not zero after reset");
  a_bus_reset_idle: assert property (@(posedge MCLK)
    !RESETN |=> !PREADY && !PSLVERR && PRDATA == 32'h0)
    else $error("bus answer not idle after reset");
  a_cfg_reset_zero: assert property (@(posedge MCLK)
    !RESETN |=> CFG == '0)
    else $error("configuration not cleared by reset");

  // --------------------------------------------------------------------------
  // Bus protocol checks
  // --------------------------------------------------------------------------
  // Zero wait states: each setup cycle is answered on the next edge
  a_ready_after_setup: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    setup |=> PREADY)
    else $error("ready missing after setup");
  // Ready is a one-cycle pulse so a held strobe cannot store twice
  a_ready_one_cycle: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  // Unmapped or misaligned offsets are refused with an error
  a_unmapped_error: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    setup && !mapped |=> PSLVERR && PREADY)
    else $error("unmapped access not flagged");
  // Mapped offsets never report an error
  a_mapped_no_error: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    setup && mapped |=> !PSLVERR)
    else $error("mapped access flagged as error");
  // Error only ever travels with ready
  a_error_with_ready: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    PSLVERR |-> PREADY)
    else $error("error raised without ready");

  // --------------------------------------------------------------------------
  // Storage checks
  // --------------------------------------------------------------------------
  // Full-word writes land on the access edge, one register each
  a_store_fault_one: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    PSEL && PENABLE && PWRITE && PREADY && hit_one && PSTRB == 4'hF
    |=> fault_one_reg == $past(PWDATA))
    else $error("fault setup one write lost");
  a_store_fault_two: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    PSEL && PENABLE && PWRITE && PREADY && hit_two && PSTRB == 4'hF
    |=> fault_two_reg == $past(PWDATA))
    else $error("fault setup two write lost");
  a_store_speed_six: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    PSEL && PENABLE && PWRITE && PREADY && hit_six && PSTRB == 4'hF
    |=> speed_six_reg == $past(PWDATA))
    else $error("speed curve six write lost");
  // A cleared strobe keeps the top lane of the stop threshold
  a_strobe_keeps_lane: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    PSEL && PENABLE && PWRITE && PREADY && hit_six && !PSTRB[3]
    |=> speed_six_reg[31:24] == $past(speed_six_reg[31:24]))
    else $error("masked lane of speed curve six changed");
  // Refused writes leave every register as it was
  a_refused_no_store: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    PSEL && PENABLE && PWRITE && PREADY && !mapped
    |=> $stable(fault_one_reg) && $stable(fault_two_reg)
        && $stable(speed_six_reg))
    else $error("refused write changed a register");

  // --------------------------------------------------------------------------
  // Field checks
  // --------------------------------------------------------------------------
  // Thresholds appear two edges after a full-word write
  a_stop_b_field: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    PSEL && PENABLE && PWRITE && PREADY && hit_six && PSTRB == 4'hF
    |=> ##1 CFG.motor_stop_threshold_b == $past(PWDATA[30:23], 2))
    else $error("stop threshold b wrong field");
  a_clamp_b_field: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    PSEL && PENABLE && PWRITE && PREADY && hit_six && PSTRB == 4'hF
    |=> ##1 CFG.clamp_threshold_b == $past(PWDATA[22:15], 2))
    else $error("clamp threshold b wrong field");
  // Once programmed, thresholds follow the register one edge later
  a_stop_b_track: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    six_written_reg && $past(RESETN)
    |-> CFG.motor_stop_threshold_b == $past(speed_six_reg[30:23]))
    else $error("stop threshold b not tracking");
  a_clamp_b_track: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    six_written_reg && $past(RESETN)
    |-> CFG.clamp_threshold_b == $past(speed_six_reg[22:15]))
    else $error("clamp threshold b not tracking");
  // Torque code copied one edge after the register
  a_torque_ref_track: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    $past(RESETN)
    |-> CFG.torque_current_reference == $past(fault_one_reg[30:27]))
    else $error("torque code not tracking");
  // Codes 0 to 2 double from 125 mA
  a_torque_ref_map: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    $past(RESETN) && CFG.torque_current_reference < 4'h3
    |-> CFG.torque_current_ma == (16'h007D << CFG.torque_current_reference))
    else $error("torque reference mapping wrong");
  // Codes 3 to D climb in 500 mA steps from 1000 mA
  a_torque_mid_steps: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    $past(RESETN) && CFG.torque_current_reference inside {[4'h3:4'hD]}
    |-> CFG.torque_current_ma
        == ({12'h000, CFG.torque_current_reference} - 16'h0001) * 16'h01F4)
    else $error("torque mid step wrong");
  // The two top codes jump by a full amp each
  a_torque_top_codes: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    $past(RESETN) && CFG.torque_current_reference[3:1] == 3'b111
    |-> CFG.torque_current_ma
        == (CFG.torque_current_reference[0] ? 16'h1F40 : 16'h1B58))
    else $error("torque top code wrong");

  // --------------------------------------------------------------------------
  // Read path checks
  // --------------------------------------------------------------------------
  // Read data is captured in setup from the addressed register
  a_read_fault_one: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    setup && !PWRITE && hit_one |=> PRDATA == $past(fault_one_reg))
    else $error("fault setup one read mismatch");
  a_read_fault_two: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    setup && !PWRITE && hit_two |=> PRDATA == $past(fault_two_reg))
    else $error("fault setup two read mismatch");
  a_speed_read_back: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    setup && !PWRITE && hit_six |=> PRDATA == $past(speed_six_reg))
    else $error("speed curve six read mismatch");
  a_read_unmapped_zero: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    setup && !PWRITE && !mapped |=> PRDATA == 32'h0)
    else $error("refused read not zero");
  // Read data stands until the next read setup
  a_read_data_hold: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    !(setup && !PWRITE) |=> $stable(PRDATA))
    else $error("read data changed without a read");

  // Main scenarios worth seeing at least once
  c_write_speed: cover property (@(posedge MCLK)
    PSEL && PENABLE && PWRITE && PREADY && hit_six);
  c_write_fault: cover property (@(posedge MCLK)
    PSEL && PENABLE && PWRITE && PREADY && hit_one);
  c_unmapped: cover property (@(posedge MCLK) PSLVERR);
  c_read_speed: cover property (@(posedge MCLK)
    setup && !PWRITE && hit_six);
  c_torque_top: cover property (@(posedge MCLK)
    CFG.torque_current_reference == 4'hF);

endmodule : msf_regs

// File: test/msf_regs_tb_top.sv
// Self-checking bench for the speed and fault setup register bank
module msf_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  localparam logic [11:0] a1 = 12'(msf_pkg::FAULT_SETUP_ONE_IDX) << 2;
  localparam logic [11:0] a2 = 12'(msf_pkg::FAULT_SETUP_TWO_IDX) << 2;
  localparam logic [11:0] a6 = 12'(msf_pkg::SPEED_CURVE_SIX_IDX) << 2;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  msf_pkg::msf_cfg_t cfg;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [31:0] v;
  logic err;
  logic [11:0] bad_a [4] = '{12'h244, 12'h241, 12'hC00, 12'h000};
  always #50 mclk = ~mclk;
  msf_regs dut (.MCLK(mclk), .RESETN(resetn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CFG(cfg));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Expected current in mA; steps change width at both ends of the range
  function automatic logic [15:0] ma_of(input logic [3:0] c);
    if (c < 4'h3)
      return 16'(32'h7D << c);
    if (c < 4'hE)
      return 16'((c - 4'h1) * 32'h1F4);
    return (c == 4'hE) ? 16'h1B58 : 16'h1F40;
  endfunction : ma_of
  // One transfer, request held until PREADY is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Reads ignore strobes, so random ones are sent to prove it
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, $urandom, 4'($urandom));
    chk("readback", rd, e);
  endtask : rd_chk
  // Hang guard: a stuck handshake ends the run as a failure
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc >= 5000)
    begin
      n_errors++;
      test_done();
    end
  end
  // Main sequence; second pass checks a reset taken in mid-run
  initial
  begin
    void'($urandom(52247));
    for (int p = 0; p < 2; p++)
    begin
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      rd_chk(a1, 32'h0000_0000);
      rd_chk(a2, 32'h0000_0000);
      chk("ma", 32'(cfg.torque_current_ma), 32'h0000_007D);
      if (p == 0)
      begin
        for (int c = 0; c < 16; c++)
        begin
          v = $urandom;
          v[30:27] = 4'(c);
          apb(1'b1, a1, v, 4'hF);
          chk("ok err", 32'(err), 32'h0000_0000);
          rd_chk(a1, v);
          chk("ref", 32'(cfg.torque_current_reference), 32'(c));
          chk("ma", 32'(cfg.torque_current_ma), 32'(ma_of(4'(c))));
        end
        for (int i = 0; i < 6; i++)
        begin
          v = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : $urandom;
          apb(1'b1, a6, v, 4'hF);
          rd_chk(a6, v);
          chk("stop", 32'(cfg.motor_stop_threshold_b), 32'(v[30:23]));
          chk("clamp", 32'(cfg.clamp_threshold_b), 32'(v[22:15]));
        end
        apb(1'b1, a6, 32'hFFFF_FFFF, 4'h5);
        v = (v & 32'hFF00_FF00) | 32'h00FF_00FF;
        rd_chk(a6, v);
        chk("clamp", 32'(cfg.clamp_threshold_b), 32'(v[22:15]));
        apb(1'b1, a2, 32'hA5C3_0F96, 4'hF);
        rd_chk(a2, 32'hA5C3_0F96);
        foreach (bad_a[k])
        begin
          apb(1'b1, bad_a[k], $urandom, 4'hF);
          chk("wr err", 32'(err), 32'h0000_0001);
          rd_chk(bad_a[k], 32'h0000_0000);
          chk("rd err", 32'(err), 32'h0000_0001);
        end
        rd_chk(a6, v);
      end
    end
    test_done();
  end
endmodule : msf_regs_tb_top
